// *** rtl/lane_if.sv ***
// static memory connection: bundle between sequencer and pin multiplexer
// assumes both ends sit on the same clock
`default_nettype none

interface lane_if;
  static_mem_ctrl_pkg::bus_width_t width;
  logic                            byte_write;
  logic                            active;
  logic                            rd_pulse;
  logic                            wr_pulse;
  logic [1:0]                      a_lo;
  logic [3:0]                      lane_en;
  logic                            pin0;
  logic                            pin_we;
  logic                            pin1;
  logic                            pin2;
  logic                            pin3;

  modport ctrl (
    output width, byte_write, active, rd_pulse, wr_pulse, a_lo, lane_en,
    input  pin0, pin_we, pin1, pin2, pin3
  );
  modport mux (
    input  width, byte_write, active, rd_pulse, wr_pulse, a_lo, lane_en,
    output pin0, pin_we, pin1, pin2, pin3
  );
endinterface

`default_nettype wire

// *** rtl/lane_pin_mux.sv ***
// static memory connection: shared lane and low address pin multiplexer
// assumes inputs from the sequencer, with width and lane type decoded from its configuration ports
`default_nettype none

module lane_pin_mux
  import static_mem_ctrl_pkg::*;
(
  lane_if.mux lanes
);

  logic [3:0] sel_n;
  logic [3:0] wr_n;

  // byte selects follow address timing, byte writes follow the strobe
  assign sel_n = ~({4{lanes.active}} & lanes.lane_en);
  assign wr_n  = ~({4{lanes.wr_pulse}} & lanes.lane_en);

  // ==========================================================
  // pin sharing per width and lane access type
  always_comb begin
    lanes.pin0   = 1'b1;
    lanes.pin_we = ~lanes.wr_pulse;
    lanes.pin1   = 1'b1;
    lanes.pin2   = lanes.a_lo[1];
    lanes.pin3   = 1'b1;
    unique case (lanes.width)
      WIDTH_16: begin
        if (lanes.byte_write) begin
          lanes.pin_we = wr_n[0];
          lanes.pin1   = wr_n[1];
        end else begin
          lanes.pin0 = sel_n[0];
          lanes.pin1 = sel_n[1];
        end
      end
      WIDTH_32: begin
        if (lanes.byte_write) begin
          lanes.pin_we = wr_n[0];
          lanes.pin1   = wr_n[1];
          lanes.pin2   = wr_n[2];
          lanes.pin3   = wr_n[3];
        end else begin
          lanes.pin0 = sel_n[0];
          lanes.pin1 = sel_n[1];
          lanes.pin2 = sel_n[2];
          lanes.pin3 = sel_n[3];
        end
      end
      default: begin
        // 8-bit and reserved codes: shared pins carry address bits
        lanes.pin0 = lanes.a_lo[0];
      end
    endcase
  end

endmodule // lane_pin_mux

`default_nettype wire

// *** rtl/static_mem_ctrl.sv ***
// static memory connection: access sequencer and external pin driver
// assumes a requester that holds a request until req_ready, with
// per-chip-select configuration held steady while an access runs
`default_nettype none
`include "static_mem_ctrl_regs.svh"

module static_mem_ctrl
  import static_mem_ctrl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             req_valid,
  output logic                  req_ready,
  input  wire logic             req_write,
  input  wire logic [28:0]      req_addr,
  input  wire logic [31:0]      req_wdata,
  input  wire logic [3:0]       req_be,
  output logic                  resp_valid,
  output logic [31:0]           resp_rdata,
  input  wire logic [7:0][1:0]  bus_width_sel,
  input  wire logic [7:0]       lane_access_type,
  input  wire logic [7:0][5:0]  setup_cycles,
  input  wire logic [7:0][5:0]  pulse_cycles,
  input  wire logic [7:0][5:0]  hold_cycles,
  input  wire logic [7:0]       page_mode_en,
  input  wire logic [7:0][1:0]  page_size_sel,
  input  wire logic             slow_clock_mode,
  input  wire logic             boot_mode,
  output logic [7:0]            chip_select_n,
  output logic [25:2]           ext_addr,
  output logic                  read_strobe_n,
  output logic                  write_strobe_n,
  output logic                  lane0_select_n,
  output logic                  lane1_write_n,
  output logic                  lane2_write_n,
  output logic                  lane3_write_n,
  output logic [31:0]           data_out,
  output logic                  data_oe,
  input  wire logic [31:0]      data_in,
  input  wire logic             ext_wait_n
);
  import static_mem_ctrl_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [3:0] lane_mask(input bus_width_t w,
                                           input logic [3:0] be,
                                           input logic [1:0] beat);
    unique case (w)
      WIDTH_16: lane_mask = beat[0] ? {2'h0, be[3:2]} : {2'h0, be[1:0]};
      WIDTH_32: lane_mask = be;
      default:  lane_mask = {3'h0, be[beat]};
    endcase
  endfunction

  function automatic logic [2:0] beats_of(input bus_width_t w);
    unique case (w)
      WIDTH_16: beats_of = 3'h2;
      WIDTH_32: beats_of = 3'h1;
      default:  beats_of = 3'h4;
    endcase
  endfunction

  // first enabled beat at or after the start, or above cur
  function automatic logic [2:0] find_beat(input bus_width_t w,
                                           input logic [3:0] be,
                                           input logic from_start,
                                           input logic [1:0] cur);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (i < int'(beats_of(w)) && (from_start || i > int'(cur)) &&
          lane_mask(w, be, 2'(i)) != 4'h0) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [25:0] beat_addr(input bus_width_t w,
                                            input logic [25:0] a,
                                            input logic [1:0] beat);
    unique case (w)
      WIDTH_16: beat_addr = {a[25:2], beat[0], 1'b0};
      WIDTH_32: beat_addr = {a[25:2], 2'h0};
      default:  beat_addr = {a[25:2], beat};
    endcase
  endfunction

  // ==========================================================
  // state
  access_state_t state;
  access_state_t next_state;
  logic [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0] next_cnt;
  logic [1:0]  beat;
  logic [1:0]  next_beat;
  logic        r_write;
  logic [2:0]  r_cs;
  logic [25:0] r_addr;
  logic [31:0] r_wdata;
  logic [3:0]  r_be;
  logic [31:0] rdata;
  logic        page_valid;
  logic [2:0]  page_cs;
  logic [25:0] page_addr;

  logic        idle;
  logic [2:0]  cur_cs;
  bus_width_t  cur_w;
  logic [3:0]  cur_be;
  logic [25:0] cur_addr;
  logic        cur_write;
  logic        cur_bw;
  logic [`CNT_W-1:0] eff_setup;
  logic [`CNT_W-1:0] eff_pulse;
  logic [`CNT_W-1:0] eff_hold;
  logic [2:0]  launch_beat;
  logic [25:0] launch_addr;
  logic [25:0] page_mask;
  logic        page_hit;
  logic        launch;
  logic        capture;
  logic        done;
  logic [25:0] pin_addr;
  logic [31:0] cur_wdata;

  assign idle      = (state == ST_IDLE);
  assign req_ready = idle;
  // window select comes from the bits above the 26 address lines
  assign cur_cs    = idle ? req_addr[28:`CS_LSB] : r_cs;
  assign cur_w     = bus_width_t'(bus_width_sel[cur_cs]);
  assign cur_be    = idle ? req_be : r_be;
  assign cur_addr  = idle ? req_addr[25:0] : r_addr;
  assign cur_write = idle ? req_write : r_write;
  assign cur_wdata = idle ? req_wdata : r_wdata;
  // a boot chip select is forced to byte-select lanes
  assign cur_bw    = lane_access_type[cur_cs] &
                     ~(boot_mode && cur_cs == 3'h0);

  assign eff_setup = slow_clock_mode ? `SLOW_SETUP
                                     : setup_cycles[cur_cs];
  assign eff_pulse = slow_clock_mode ? `SLOW_PULSE
                                     : pulse_cycles[cur_cs];
  assign eff_hold  = slow_clock_mode ? `SLOW_HOLD
                                     : hold_cycles[cur_cs];

  assign launch_beat = find_beat(cur_w, cur_be, idle, beat);
  assign launch_addr = beat_addr(cur_w, cur_addr, launch_beat[1:0]);
  assign page_mask   = 26'h3ffffff <<
                       (`PAGE_LSB_BASE + page_size_sel[cur_cs]);
  // a read inside the open page skips the setup phase
  assign page_hit = page_mode_en[cur_cs] && !slow_clock_mode &&
                    !cur_write && page_valid && page_cs == cur_cs &&
                    (page_addr & page_mask) ==
                    (launch_addr & page_mask);

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_beat  = beat;
    launch     = 1'b0;
    capture    = 1'b0;
    done       = 1'b0;
    unique case (state)
      ST_IDLE: begin
        launch = req_valid;
      end
      ST_SETUP: begin
        if (cnt <= 6'h01) begin
          next_state = ST_PULSE;
          next_cnt   = eff_pulse;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
      ST_PULSE: begin
        // wait low holds the pulse and its counter
        if (ext_wait_n) begin
          if (cnt <= 6'h01) begin
            capture = !r_write;
            if (eff_hold != 6'h00) begin
              next_state = ST_HOLD;
              next_cnt   = eff_hold;
            end else begin
              launch = 1'b1;
            end
          end else begin
            next_cnt = cnt - 6'h01;
          end
        end
      end
      ST_HOLD: begin
        if (cnt <= 6'h01) begin
          launch = 1'b1;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
    endcase
    if (launch) begin
      if (!launch_beat[2]) begin
        next_state = ST_IDLE;
        done       = 1'b1;
      end else begin
        next_beat = launch_beat[1:0];
        if (page_hit || eff_setup == 6'h00) begin
          next_state = ST_PULSE;
          next_cnt   = eff_pulse;
        end else begin
          next_state = ST_SETUP;
          next_cnt   = eff_setup;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cnt   <= 6'h00;
      beat  <= 2'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      beat  <= next_beat;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_write <= 1'b0;
      r_cs    <= 3'h0;
      r_addr  <= 26'h0000000;
      r_wdata <= 32'h00000000;
      r_be    <= 4'h0;
    end else if (idle && req_valid) begin
      r_write <= req_write;
      r_cs    <= req_addr[28:`CS_LSB];
      r_addr  <= req_addr[25:0];
      r_wdata <= req_wdata;
      r_be    <= req_be;
    end
  end

  // ==========================================================
  // read data, sampled on the edge that ends the read pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else if (idle && req_valid) begin
      rdata <= 32'h00000000;
    end else if (capture) begin
      unique case (cur_w)
        WIDTH_16: rdata[16*beat[0] +: 16] <= data_in[15:0];
        WIDTH_32: rdata <= data_in;
        default:  rdata[8*beat +: 8] <= data_in[7:0];
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= done;
    end
  end
  assign resp_rdata = rdata;

  // open page tracking; writes and slow mode close it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_valid <= 1'b0;
      page_cs    <= 3'h0;
      page_addr  <= 26'h0000000;
    end else if (slow_clock_mode || (idle && req_valid && req_write)) begin
      page_valid <= 1'b0;
    end else if (capture) begin
      page_valid <= page_mode_en[r_cs];
      page_cs    <= r_cs;
      page_addr  <= beat_addr(cur_w, r_addr, beat);
    end
  end

  // ==========================================================
  // write data: narrow devices take their beat on the low lanes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_out <= 32'h00000000;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= cur_write && next_state != ST_IDLE;
      if (launch && launch_beat[2] && cur_write) begin
        unique case (cur_w)
          WIDTH_16: data_out <= {16'h0000,
                                 cur_wdata[16*launch_beat[0] +: 16]};
          WIDTH_32: data_out <= cur_wdata;
          default:  data_out <= {24'h000000,
                                 cur_wdata[8*launch_beat[1:0] +: 8]};
        endcase
      end
    end
  end

  // ==========================================================
  // pins; chip select stands for the whole access, address and lane selects change with each beat
  lane_if lanes ();

  assign lanes.width      = cur_w;
  assign lanes.byte_write = cur_bw;
  assign lanes.active     = !idle;
  assign lanes.rd_pulse   = state == ST_PULSE && !r_write;
  assign lanes.wr_pulse   = state == ST_PULSE && r_write;
  assign pin_addr         = beat_addr(cur_w, r_addr, beat);
  assign lanes.a_lo       = pin_addr[1:0];
  assign lanes.lane_en    = lane_mask(cur_w, r_be, beat);

  lane_pin_mux u_lane_pin_mux (
    .lanes (lanes.mux)
  );

  assign chip_select_n  = idle ? 8'hff : ~(8'h01 << r_cs);
  // lines 25:2 always driven; shared lane pins add line 1 for 16-bit and lines 1:0 for 8-bit
  assign ext_addr       = pin_addr[25:2];
  assign read_strobe_n  = ~lanes.rd_pulse;
  assign write_strobe_n = lanes.pin_we;
  assign lane0_select_n = lanes.pin0;
  assign lane1_write_n  = lanes.pin1;
  assign lane2_write_n  = lanes.pin2;
  assign lane3_write_n  = lanes.pin3;

endmodule // static_mem_ctrl

`default_nettype wire

// *** rtl/static_mem_ctrl_pkg.sv ***
// static memory connection: shared types
// assumes no surroundings beyond the compile order
`default_nettype none

package static_mem_ctrl_pkg;

  typedef enum logic [1:0] {
    WIDTH_8  = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_32 = 2'h2
  } bus_width_t;

  // gray codes along idle, setup, pulse, hold
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SETUP = 2'h1,
    ST_PULSE = 2'h3,
    ST_HOLD  = 2'h2
  } access_state_t;

endpackage

`default_nettype wire

// *** rtl/static_mem_ctrl_regs.svh ***
// static memory connection: sizes, counts and fixed slow-clock timing
// assumes inclusion by bare name from the design files
`ifndef STATIC_MEM_CTRL_REGS_SVH
`define STATIC_MEM_CTRL_REGS_SVH

`define NUM_CS        8
`define ADDR_W        26
`define CS_LSB        26
`define CNT_W         6
// fixed waveforms used while slow clock mode is active
`define SLOW_SETUP    6'h01
`define SLOW_PULSE    6'h01
`define SLOW_HOLD     6'h01
// page size codes: 4, 8, 16, 32 bytes
`define PAGE_LSB_BASE 2

`endif

// *** tb/sram_model.sv ***
// behavioural static memory on the pin side, one store per chip select
// assumes the bench tells it each select's width and lane type
`default_nettype none
module sram_model
(
  input  wire logic            clk,
  input  wire logic [7:0][1:0] width,
  input  wire logic [7:0]      byte_write,
  input  wire logic [3:0]      stall,
  input  wire logic [7:0]      chip_select_n,
  input  wire logic [25:2]     ext_addr,
  input  wire logic            read_strobe_n,
  input  wire logic            write_strobe_n,
  input  wire logic            lane0_select_n,
  input  wire logic            lane1_write_n,
  input  wire logic            lane2_write_n,
  input  wire logic            lane3_write_n,
  input  wire logic [31:0]     data_out,
  output logic [31:0]          data_in,
  output logic                 ext_wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // upper address bits ignored, so the store repeats
  logic [7:0]  mem [0:2047];
  logic [10:0] base;
  logic [3:0]  lw;
  logic [3:0]  lanes;
  logic [2:0]  idx;
  logic [31:0] last = 32'h0;
  logic        prev_rd = 1'b1;
  logic [3:0]  wcnt = 4'h0;
  always_comb begin
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (!chip_select_n[i]) idx = 3'(i);
    end
    lanes = 4'h1;
    base = {idx, ext_addr[7:2], lane2_write_n, lane0_select_n};
    if (width[idx] == 2'h1) begin
      lanes = 4'h3;
      base[0] = 1'b0;
    end
    if (width[idx] == 2'h2) begin
      lanes = 4'hf;
      base[1:0] = 2'h0;
    end
    if (byte_write[idx])
      lw = ~{lane3_write_n, lane2_write_n, lane1_write_n, write_strobe_n};
    else
      lw = ~{lane3_write_n, lane2_write_n, lane1_write_n, lane0_select_n}
           & {4{~write_strobe_n}};
    if (lanes == 4'h1) lw = {3'h0, ~write_strobe_n};
    lw = lw & lanes & {4{chip_select_n != 8'hff}};
    // released lanes show the inverse of the last value, never a hold
    data_in = ~last;
    for (int i = 0; i < 4; i++) begin
      if (!read_strobe_n && lanes[i]) data_in[8*i +: 8] = mem[base + 11'(i)];
    end
  end
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (lw[i]) mem[base + 11'(i)] <= data_out[8*i +: 8];
    end
    last <= data_in;
    prev_rd <= read_strobe_n;
    if (!read_strobe_n && prev_rd && stall != 4'h0) wcnt <= stall;
    else if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
  end
  assign ext_wait_n = wcnt == 4'h0;
endmodule // sram_model
`default_nettype wire

// *** tb/static_mem_ctrl_asserts.sv ***
// checker for the static memory pins of static_mem_ctrl
// assumes configuration ports stay steady while an access runs
`default_nettype none
module static_mem_ctrl_asserts
(
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic [7:0][1:0] bus_width_sel,
  input  wire logic [7:0]      lane_access_type,
  input  wire logic            slow_clock_mode,
  input  wire logic            boot_mode,
  input  wire logic [7:0]      chip_select_n,
  input  wire logic            read_strobe_n,
  input  wire logic            write_strobe_n,
  input  wire logic            lane0_select_n,
  input  wire logic            lane1_write_n,
  input  wire logic            lane3_write_n,
  input  wire logic            data_oe,
  input  wire logic            ext_wait_n
);
  // ==========
  // decode of the running chip select
  logic [2:0] idx;
  logic       act;
  logic       w8;
  logic       w32;
  logic       bwr;
  always_comb begin
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (!chip_select_n[i]) idx = 3'(i);
    end
  end
  assign act = chip_select_n != 8'hff;
  // code 3 behaves as 8-bit, so equal bits mean narrow
  assign w8  = bus_width_sel[idx][1] == bus_width_sel[idx][0];
  assign w32 = bus_width_sel[idx] == 2'h2;
  assign bwr = lane_access_type[idx] && !w8 && !(boot_mode && idx == 3'h0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========
  // pin relations
  chk_cs_onehot: assert property (
    $onehot0(~chip_select_n)) else $error("two chip selects low");
  chk_rd_in_cs: assert property (
    !read_strobe_n |-> act) else $error("read strobe without select");
  chk_rd_wr_excl: assert property (
    !read_strobe_n |-> write_strobe_n) else $error("read and write low");
  chk_write_drives: assert property (
    !write_strobe_n |-> data_oe) else $error("write without data drive");
  chk_narrow_lane3: assert property (
    act && !w32 |-> lane3_write_n) else $error("lane3 used on narrow bus");
  chk_bw_no_select: assert property (
    act && bwr |-> lane0_select_n) else $error("lane0 select in byte write");
  chk_8bit_lane1: assert property (
    act && w8 |-> lane1_write_n) else $error("lane1 used on 8-bit bus");
  chk_wait_freeze: assert property (
    !read_strobe_n && !ext_wait_n |=> !read_strobe_n)
    else $error("strobe ended while wait held");
  chk_slow_pulse: assert property (
    slow_clock_mode && $fell(read_strobe_n) && ext_wait_n |=> read_strobe_n)
    else $error("slow mode pulse not one cycle");
endmodule // static_mem_ctrl_asserts

bind static_mem_ctrl static_mem_ctrl_asserts static_mem_ctrl_asserts_inst (
  .clk(clk), .nrst(nrst), .bus_width_sel(bus_width_sel),
  .lane_access_type(lane_access_type), .slow_clock_mode(slow_clock_mode),
  .boot_mode(boot_mode), .chip_select_n(chip_select_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .lane0_select_n(lane0_select_n), .lane1_write_n(lane1_write_n),
  .lane3_write_n(lane3_write_n), .data_oe(data_oe), .ext_wait_n(ext_wait_n));
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the static memory connection
// assumes design files and sram_model compile first
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin n_errors++; \
  $display("unexpected %s: expected %h seen %h", nm, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // signals and bookkeeping
  logic clk, nrst, req_valid, req_ready, req_write, resp_valid, data_oe;
  logic slow_clock_mode, boot_mode, read_strobe_n, write_strobe_n;
  logic lane0_select_n, lane1_write_n, lane2_write_n, lane3_write_n;
  logic ext_wait_n;
  logic [28:0]     req_addr;
  logic [31:0]     req_wdata, resp_rdata, data_out, data_in;
  logic [3:0]      req_be, stall;
  logic [7:0][1:0] bus_width_sel, page_size_sel;
  logic [7:0][5:0] setup_cycles, pulse_cycles, hold_cycles;
  logic [7:0]      lane_access_type, page_mode_en, chip_select_n, eff_bw;
  logic [25:2]     ext_addr;
  logic [7:0]      shadow [0:2047];
  typedef struct { logic rd; logic [31:0] d; int lat; int take; } note_t;
  note_t notes[$];
  int seed = 73229;
  int cyc = 0;
  int n_errors = 0;
  int n_checks = 0;

  static_mem_ctrl static_mem_ctrl_inst (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .bus_width_sel(bus_width_sel), .lane_access_type(lane_access_type),
    .setup_cycles(setup_cycles), .pulse_cycles(pulse_cycles),
    .hold_cycles(hold_cycles), .page_mode_en(page_mode_en),
    .page_size_sel(page_size_sel), .slow_clock_mode(slow_clock_mode),
    .boot_mode(boot_mode), .chip_select_n(chip_select_n),
    .ext_addr(ext_addr), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .lane0_select_n(lane0_select_n),
    .lane1_write_n(lane1_write_n), .lane2_write_n(lane2_write_n),
    .lane3_write_n(lane3_write_n), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .ext_wait_n(ext_wait_n));
  sram_model sram_model_inst (.clk(clk), .width(bus_width_sel),
    .byte_write(eff_bw), .stall(stall), .chip_select_n(chip_select_n),
    .ext_addr(ext_addr), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .lane0_select_n(lane0_select_n),
    .lane1_write_n(lane1_write_n), .lane2_write_n(lane2_write_n),
    .lane3_write_n(lane3_write_n), .data_out(data_out),
    .data_in(data_in), .ext_wait_n(ext_wait_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ==========
  // response watcher
  always @(negedge clk) begin
    note_t n;
    if (nrst && resp_valid) begin
      if (notes.size() == 0) begin
        n_errors++;
        $display("unexpected response: expected none seen %h", resp_rdata);
      end else begin
        n = notes.pop_front();
        `CHK("latency", n.lat, cyc - n.take)
        if (n.rd) `CHK("read data", n.d, resp_rdata)
      end
    end
  end
  // ==========
  // tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic int lat_of(input int c, input logic [3:0] be,
                                input bit pg);
    int s;
    int b;
    s = setup_cycles[c] + pulse_cycles[c] + hold_cycles[c];
    if (pg) s = s - setup_cycles[c];
    if (slow_clock_mode) s = 3;
    case (bus_width_sel[c])
      2'h2: b = (be != 4'h0);
      2'h1: b = (be[1:0] != 2'h0) + (be[3:2] != 2'h0);
      default: b = be[0] + be[1] + be[2] + be[3];
    endcase
    return b * s + 1;
  endfunction
  // requests are held until taken; caller sits 1 ns after an edge
  task automatic req(input logic wr, input logic [28:0] a,
                     input logic [31:0] d, input logic [3:0] be, input int lat);
    note_t n;
    int k;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_be = be;
    for (k = 0; k < 300 && req_ready !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (req_ready !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    @(posedge clk);
    n.rd = !wr;
    n.lat = lat;
    n.take = cyc;
    for (k = 0; k < 4; k++) begin
      if (wr && be[k]) shadow[{a[28:26], a[7:0]} + 11'(k)] = d[8*k +: 8];
      n.d[8*k +: 8] = shadow[{a[28:26], a[7:0]} + 11'(k)];
    end
    notes.push_back(n);
    #1;
  endtask
  task automatic idle();
    req_valid = 1'b0;
    for (int k = 0; k < 300 && notes.size() != 0; k++) begin
      @(posedge clk);
      #1;
    end
    if (notes.size() != 0) begin
      n_errors++;
      stop_test();
    end
  endtask
  // full write, random partial write, read back through an alias
  task automatic pass(input int c);
    logic [28:0] a;
    logic [31:0] d;
    logic [3:0]  be;
    for (int i = 0; i < 3; i++) begin
      a = {3'(c), 18'($random(seed)), 6'(i), 2'h0};
      d = $random(seed);
      be = 4'($random(seed));
      req(1'b1, a, d, 4'hf, lat_of(c, 4'hf, 0));
      req(1'b1, a, ~d, be, lat_of(c, be, 0));
      req(1'b0, {a[28:26], ~a[25:8], a[7:0]}, 0, 4'hf, lat_of(c, 4'hf, 0));
    end
  endtask
  // ==========
  // main sequence
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 29'h0;
    req_wdata = 32'h0;
    req_be = 4'h0;
    slow_clock_mode = 1'b0;
    boot_mode = 1'b1;
    stall = 4'h0;
    page_mode_en = 8'h20;
    page_size_sel = {8{2'h3}};
    bus_width_sel = {2'h3, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h0, 2'h2};
    lane_access_type = 8'h89;
    eff_bw = 8'h88;
    for (int c = 0; c < 8; c++) begin
      setup_cycles[c] = 6'({$random(seed)} % 3);
      pulse_cycles[c] = 6'(1 + {$random(seed)} % 3);
      hold_cycles[c] = 6'({$random(seed)} % 3);
    end
    pulse_cycles[4] = 6'h3;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    for (int c = 0; c < 8; c++) pass(c);
    req(1'b0, 29'h14000000, 0, 4'hf, lat_of(5, 4'hf, 0));
    req(1'b0, 29'h14000004, 0, 4'hf, lat_of(5, 4'hf, 1));
    idle();
    stall = 4'h4;
    req(1'b0, 29'h10000000, 0, 4'hf, lat_of(4, 4'hf, 0) + 4);
    req(1'b0, 29'h10000004, 0, 4'hf, lat_of(4, 4'hf, 0) + 4);
    idle();
    stall = 4'h0;
    slow_clock_mode = 1'b1;
    req(1'b0, 29'h08000000, 0, 4'hf, lat_of(2, 4'hf, 0));
    req(1'b0, 29'h04000004, 0, 4'hf, lat_of(1, 4'hf, 0));
    idle();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
